//--- tb/fsh_link_sva.sv
// Purpose: link and status checks between host and device ends
// Assumes: link signals sampled by ref_clk, sclk is much slower
// Notes: status outputs of the device end are watched too
`timescale 1ns/1ps
module fsh_link_sva
	(
		// System
		input logic ref_clk,
		input logic rst_n,
		// Link
		input logic csN,
		input logic sclk,
		input logic si,
		input logic so,
		input logic soOe,
		input logic soPin,
		// Status
		input logic write_in_progress,
		input logic write_enable_latch,
		input logic paused_state_flag
	);
	localparam int HALT_MAX = 81;
	localparam int WEL_LAG = 2;
	logic [12:0] busyCnt;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Counter, since a repetition cannot span a whole erase
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			busyCnt <= 13'h0;
		else if (write_in_progress)
			busyCnt <= busyCnt + 13'h1;
		else
			busyCnt <= 13'h0;
	end

	sequence opStart;
		$rose(write_in_progress) && !paused_state_flag && !$past(paused_state_flag);
	endsequence
	sequence haltDone;
		##[0:HALT_MAX] !write_in_progress;
	endsequence

	chk_oe_desel: assert property (csN && $past(csN) |-> !soOe)
		else $error("data out driven while deselected");
	chk_pin_pullup: assert property (csN && $past(csN) |-> soPin)
		else $error("released data line not high");
	chk_so_on_fall: assert property
		(!csN && $past(!csN) && $changed(so) |-> $fell(sclk))
		else $error("data out moved off a falling clock");
	chk_si_clk_low: assert property
		(!csN && $past(!csN) && $changed(si) |-> !sclk)
		else $error("data in moved while clock high");
	chk_sclk_frame: assert property ($rose(sclk) |-> !csN)
		else $error("link clock outside a frame");
	chk_start_closed: assert property
		($rose(write_in_progress) |-> csN && $past(csN, 2))
		else $error("operation began inside a frame");
	chk_start_wel: assert property (opStart |-> ##[0:WEL_LAG] !write_enable_latch)
		else $error("write enable kept after operation start");
	chk_sus_busy: assert property ($rose(paused_state_flag) |-> $past(write_in_progress))
		else $error("suspend taken while idle");
	chk_halt_lat: assert property ($rose(paused_state_flag) |-> haltDone)
		else $error("busy not dropped within halt time");
	chk_resume_sus: assert property
		($rose(write_in_progress) && $past(paused_state_flag) |-> !paused_state_flag)
		else $error("resume left paused flag set");
	chk_busy_bound: assert property (busyCnt <= 13'he11)
		else $error("busy longer than an erase");
	chk_wel_held: assert property (write_in_progress && $past(write_in_progress) |-> !$rose(write_enable_latch))
		else $error("write enable set while busy");
endmodule

//--- tb/tb.sv
// Purpose: runs both flash link ends against each other
// Assumes: host paces frames, second device gets broken frames
// Notes: secure register memory is erased before it is read
`timescale 1ns/1ps
`include "fsh_map.svh"
module tb;
	// Arbitrary value
	localparam logic [127:0] UID =
		128'h3c5a_9601_7e24_d1b8_0f6c_a347_52e9_8b1d;
	logic refClk = 1'b0, rstN = 1'b1, reqValid = 1'b0, reqAddrEn = 1'b0;
	logic reqDummyEn = 1'b0, reqWrite = 1'b0;
	logic reqReady, wrTake, rdValid, write_in_progress, write_enable_latch, paused_state_flag, wip2, wel2;
	logic [7:0] reqCmd = 8'h0, rdData, wrData;
	logic [23:0] reqAddr = 24'h0;
	logic [10:0] reqLen = 11'h0;
	logic [1:0] lockBits = 2'h0, wrIdx = 2'h0;
	logic [7:0] wrBuf [4] = '{8'h0, 8'h0, 8'h0, 8'h0};
	logic [7:0] rdQ [$];
	int error_cnt = 0, n_compared = 0, cycCnt = 0;
	fsh_spi_if spiBus();
	fsh_spi_if spiFlt();

	assign wrData = wrBuf[wrIdx];
	fsh_flash_host u_fsh_flash_host (.spi(spiBus), .ref_clk(refClk),
		.rst_n(rstN), .reqValid(reqValid), .reqReady(reqReady),
		.reqCmd(reqCmd), .reqAddr(reqAddr), .reqAddrEn(reqAddrEn),
		.reqDummyEn(reqDummyEn), .reqLen(reqLen), .reqWrite(reqWrite),
		.wrData(wrData), .wrTake(wrTake), .rdData(rdData),
		.rdValid(rdValid));
	fsh_flash_dev #(.UNIQUE_ID(UID)) u_fsh_flash_dev (.spi(spiBus),
		.ref_clk(refClk), .rst_n(rstN), .lockBits(lockBits), .write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch), .paused_state_flag(paused_state_flag));
	fsh_flash_dev u_fsh_flash_dev_2 (.spi(spiFlt), .ref_clk(refClk),
		.rst_n(rstN), .lockBits(2'b00), .write_in_progress(wip2), .write_enable_latch(wel2), .paused_state_flag());
	fsh_link_sva u_fsh_link_sva (.ref_clk(refClk), .rst_n(rstN),
		.csN(spiBus.csN), .sclk(spiBus.sclk), .si(spiBus.si),
		.so(spiBus.so), .soOe(spiBus.soOe), .soPin(spiBus.soPin),
		.write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch), .paused_state_flag(paused_state_flag));

	initial
	begin
		forever #12.5 refClk = ~refClk;
	end

	always @(posedge refClk)
	begin
		cycCnt <= cycCnt + 1;
		if (reqValid && reqReady)
			wrIdx <= 2'h0;
		else if (wrTake)
			wrIdx <= wrIdx + 2'h1;
		if (rdValid)
			rdQ.push_back(rdData);
		if (cycCnt == 60000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic frame(input logic [7:0] c, input logic [23:0] a,
		input logic ae, input logic de, input logic [10:0] n, input logic w);
		rdQ.delete();
		@(posedge refClk);
		while (!reqReady)
			@(posedge refClk);
		reqCmd <= c;
		reqAddr <= a;
		reqAddrEn <= ae;
		reqDummyEn <= de;
		reqLen <= n;
		reqWrite <= w;
		reqValid <= 1'b1;
		@(posedge refClk);
		reqValid <= 1'b0;
		@(posedge refClk);
		while (!reqReady)
			@(posedge refClk);
		// Margin for the device's frame end detect
		repeat (6) @(posedge refClk);
	endtask

	task automatic cmd(input logic [7:0] c);
		frame(c, 24'h0, 1'b0, 1'b0, 11'h0, 1'b0);
	endtask

	task automatic op(input logic [7:0] c, input logic [23:0] a,
		input logic [10:0] n);
		cmd(`FSH_CMD_WR_ENABLE);
		frame(c, a, 1'b1, 1'b0, n, n != 11'h0);
	endtask

	task automatic rd(input logic [23:0] a, input logic [10:0] n);
		frame(`FSH_CMD_SR_READ, a, 1'b1, 1'b1, n, 1'b0);
	endtask

	task automatic waitIdle();
		do
			@(negedge refClk);
		while (write_in_progress !== 1'b0);
		@(posedge refClk);
	endtask

	// Fault driver: own 64 ns link clock, up to 40 bits
	task automatic bang(input logic [39:0] v, input int n);
		#7 spiFlt.csN = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			spiFlt.si = v[39 - i];
			#32 spiFlt.sclk = 1'b1;
			#32 spiFlt.sclk = 1'b0;
		end
		#32 spiFlt.csN = 1'b1;
		#3000;
	endtask

	task automatic tUid();
		frame(`FSH_CMD_UID, 24'h0, 1'b1, 1'b1, 11'h10, 1'b0);
		check(rdQ.size(), 16);
		for (int i = 0; i < 16; i++)
			check(rdQ[i], UID[127 - 8 * i -: 8]);
	endtask

	task automatic tSecure();
		frame(`FSH_CMD_SR_ERASE, 24'h0, 1'b1, 1'b0, 11'h0, 1'b0);
		check(write_in_progress, 1'b0);
		op(`FSH_CMD_SR_ERASE, 24'h000400, 11'h0);
		check(write_in_progress, 1'b0);
		op(`FSH_CMD_SR_ERASE, 24'h000000, 11'h0);
		check({write_in_progress, write_enable_latch}, 2'b10);
		waitIdle();
		op(`FSH_CMD_SR_ERASE, 24'h001155, 11'h0);
		waitIdle();
		wrBuf[0] <= 8'h11;
		wrBuf[1] <= 8'h22;
		op(`FSH_CMD_SR_PROG, 24'h0013ff, 11'h2);
		check({write_in_progress, write_enable_latch}, 2'b10);
		waitIdle();
		rd(24'h0013ff, 11'h2);
		check({rdQ[0], rdQ[1]}, 16'h11ff);
		rd(24'h001300, 11'h1);
		check(rdQ[0], 8'h22);
		rd(24'h0003ff, 11'h1);
		check(rdQ[0], 8'hff);
		lockBits <= 2'b01;
		op(`FSH_CMD_SR_ERASE, 24'h001000, 11'h0);
		check(write_in_progress, 1'b0);
		lockBits <= 2'b10;
		op(`FSH_CMD_SR_PROG, 24'h000000, 11'h1);
		check(write_in_progress, 1'b0);
		lockBits <= 2'b00;
	endtask

	task automatic tSuspend();
		cmd(`FSH_CMD_SUSPEND);
		check(paused_state_flag, 1'b0);
		op(`FSH_CMD_SE, 24'h010000, 11'h0);
		cmd(`FSH_CMD_SUSPEND);
		check(paused_state_flag, 1'b1);
		repeat (80) @(posedge refClk);
		check(write_in_progress, 1'b0);
		op(`FSH_CMD_SR_ERASE, 24'h000000, 11'h0);
		check({write_in_progress, paused_state_flag}, 2'b01);
		cmd(`FSH_CMD_RESUME);
		check({write_in_progress, paused_state_flag}, 2'b10);
		waitIdle();
		op(`FSH_CMD_PP, 24'h020000, 11'h1);
		cmd(`FSH_CMD_SUSPEND);
		repeat (80) @(posedge refClk);
		op(`FSH_CMD_SR_PROG, 24'h000000, 11'h1);
		check({write_in_progress, paused_state_flag}, 2'b01);
		cmd(`FSH_CMD_RESUME);
		waitIdle();
	endtask

	task automatic tReset();
		cmd(`FSH_CMD_WR_ENABLE);
		cmd(`FSH_CMD_RST);
		check(write_enable_latch, 1'b1);
		op(`FSH_CMD_SE, 24'h010000, 11'h0);
		cmd(`FSH_CMD_SUSPEND);
		repeat (80) @(posedge refClk);
		frame(`FSH_CMD_RD_STATUS, 24'h0, 1'b0, 1'b0, 11'h1, 1'b0);
		check(rdQ[0], 8'h80);
		cmd(`FSH_CMD_WR_ENABLE);
		cmd(`FSH_CMD_RST_EN);
		cmd(`FSH_CMD_RST);
		check({write_in_progress, write_enable_latch, paused_state_flag}, 3'b000);
		cmd(`FSH_CMD_WR_ENABLE);
		check(write_enable_latch, 1'b0);
		repeat (1200) @(posedge refClk);
		cmd(`FSH_CMD_WR_ENABLE);
		check(write_enable_latch, 1'b1);
	endtask

	task automatic tFault();
		bang({`FSH_CMD_WR_ENABLE, 32'h0}, 8);
		bang({`FSH_CMD_SR_ERASE, 32'h0}, 31);
		check(wip2, 1'b0);
		bang({`FSH_CMD_SR_ERASE, 32'h0}, 33);
		check(wip2, 1'b0);
		bang({`FSH_CMD_SR_ERASE, 32'h0}, 32);
		check({wip2, wel2}, 2'b10);
	endtask

	initial
	begin
		// Real falling edge, so link side flops reset too
		rstN <= 1'b0;
		spiFlt.csN = 1'b1;
		spiFlt.sclk = 1'b0;
		spiFlt.si = 1'b0;
		repeat (6) @(posedge refClk);
		rstN <= 1'b1;
		tUid();
		tSecure();
		tSuspend();
		tReset();
		tFault();
		report_and_stop();
	end
endmodule

//--- verilog/fsh_flash_dev.sv
// Purpose: flash command engine for id, secure regs, reset, suspend
// Assumes: host stops sclk low before raising csN
// Notes: frame shifter on sclk, self-timed ops on ref_clk
// Contract
// - Unique id: 4BH, zero address, dummy, 128 bits
// - Output bits on falling edge, MSB first
// - Two independent 1024-byte secure registers
// - Secure erase 44H needs write enable latch
// - Erase frame must end after address
// - Erase sets busy, clears write enable
// - Decode register select and byte offset
// - Any lock bit blocks erase and program
// - Secure program 42H, address, data bytes
// - Program stays within one 256-byte page
// - Secure read 48H, address, dummy, data
// - Read address wraps 3FFH to 000H
// - Reset needs 66H frame then 99H frame
// - Reset aborts work, clears volatile state
// - Refuse commands during reset recovery
// - Host checks busy and paused before reset
// - Suspend only during array program/erase
// - Paused flag at once, busy drops later
// - Program suspend blocks listed commands
// - Erase suspend blocks listed commands
// - Resume clears paused, restarts operation
`timescale 1ns/1ps
`include "fsh_map.svh"
module fsh_flash_dev
	#(
		// Arbitrary value
		parameter logic [127:0] UNIQUE_ID =
			128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff
	)
	(
		// Link
		fsh_spi_if.dev spi,
		// System
		input wire logic ref_clk,
		input wire logic rst_n,
		// User
		input wire logic [1:0] lockBits,
		output logic write_in_progress,
		output logic write_enable_latch,
		output logic paused_state_flag
	);
	import fsh_pkg::*;

	logic fresh;
	logic [19:0] cnt;
	logic [19:0] curIdx;
	logic [19:0] off;
	logic [31:0] sh;
	logic [7:0] cmd;
	logic [23:0] addr;
	logic [7:0] pageBuf [256];
	logic [7:0] mem [2048];
	logic [2:0] stS1;
	logic [2:0] stS2;
	logic [7:0] stByte;
	logic [9:0] rdCol;
	logic [7:0] rdByte;
	logic nextEn;
	logic nextBit;
	logic [7:0] newByte;
	logic csS1;
	logic csS2;
	logic csS3;
	logic frameEnd;
	fsh_dev_state_e state;
	fsh_op_e op;
	fsh_op_e savedOp;
	fsh_op_e newOp;
	logic [11:0] timer;
	logic [11:0] savedTimer;
	logic [11:0] haltWait;
	logic [11:0] newTime;
	logic rstArm;
	logic startOp;
	logic addrOk;
	logic locked;
	logic dataEnd;
	logic takeSuspend;
	logic takeResume;
	logic takeReset;

	function automatic logic isErase(input logic [7:0] c);
		return c == `FSH_CMD_SE || c == `FSH_CMD_BE32 || c == `FSH_CMD_BE64
			|| c == `FSH_CMD_CE1 || c == `FSH_CMD_CE2;
	endfunction

	function automatic logic refused(input logic [7:0] c, input logic s,
		input fsh_op_e o);
		logic common;
		common = c == `FSH_CMD_WR_STATUS || c == `FSH_CMD_SR_ERASE
			|| isErase(c);
		if (!s)
			return 1'b0;
		if (o == FO_PROG)
			return common || c == `FSH_CMD_SR_PROG || c == `FSH_CMD_PP
				|| c == `FSH_CMD_QPP;
		return common;
	endfunction

	// Sclk domain: frame shifter
	assign curIdx = fresh ? 20'h0 : cnt;
	assign newByte = {sh[6:0], spi.si};

	always_ff @(posedge spi.sclk or posedge spi.csN)
		if (spi.csN)
			fresh <= 1'b1;
		else
			fresh <= 1'b0;

	always_ff @(posedge spi.sclk or negedge rst_n)
		if (!rst_n)
		begin
			cnt <= 20'h0;
			sh <= 32'h0;
			cmd <= 8'h0;
			addr <= 24'h0;
		end
		else
		begin
			cnt <= (&curIdx) ? curIdx : curIdx + 20'h1;
			sh <= {sh[30:0], spi.si};
			if (curIdx == `FSH_BITS_CMD - 20'h1)
				cmd <= newByte;
			if (curIdx == `FSH_BITS_ADDR - 20'h1)
				addr <= {sh[22:0], spi.si};
		end

	// data bytes wrap inside the page
	always_ff @(posedge spi.sclk)
		if (curIdx == `FSH_BITS_CMD - 20'h1 && newByte == `FSH_CMD_SR_PROG)
		begin
			for (int j = 0; j < 256; j++)
				pageBuf[j] <= 8'hff;
		end
		else if (cmd == `FSH_CMD_SR_PROG && curIdx[2:0] == 3'h7
			&& curIdx >= `FSH_BITS_DUMMY - 20'h1)
			pageBuf[8'(addr[7:0] + curIdx[10:3] - 8'h4)] <= newByte;

	// Status crosses into sclk domain; stale by two edges at most
	always_ff @(posedge spi.sclk or negedge rst_n)
		if (!rst_n)
		begin
			stS1 <= 3'h0;
			stS2 <= 3'h0;
		end
		else
		begin
			stS1 <= {paused_state_flag, write_enable_latch, write_in_progress};
			stS2 <= stS1;
		end

	always_comb
	begin
		stByte = 8'h0;
		stByte[`FSH_ST_WIP] = stS2[0];
		stByte[`FSH_ST_WEL] = stS2[1];
		stByte[`FSH_ST_SUS] = stS2[2];
	end

	assign off = cnt - `FSH_BITS_DUMMY;
	assign rdCol = 10'(addr[9:0] + off[12:3]);
	assign rdByte = mem[{addr[12], rdCol}];

	always_comb
	begin
		nextEn = 1'b0;
		nextBit = 1'b0;
		case (cmd)
			`FSH_CMD_RD_STATUS:
			begin
				nextEn = cnt >= `FSH_BITS_CMD;
				nextBit = stByte[3'h7 - cnt[2:0]];
			end
			`FSH_CMD_UID:
			begin
				nextEn = cnt >= `FSH_BITS_DUMMY;
				nextBit = off < 20'h80 && UNIQUE_ID[7'h7f - off[6:0]];
			end
			`FSH_CMD_SR_READ:
			begin
				nextEn = cnt >= `FSH_BITS_DUMMY;
				nextBit = rdByte[3'h7 - off[2:0]];
			end
			default:
			begin
				nextEn = 1'b0;
				nextBit = 1'b0;
			end
		endcase
	end

	// drive on falling edge, MSB first
	always_ff @(negedge spi.sclk or posedge spi.csN)
		if (spi.csN)
		begin
			spi.so <= 1'b0;
			spi.soOe <= 1'b0;
		end
		else
		begin
			spi.so <= nextBit;
			spi.soOe <= nextEn;
		end

	// Ref domain: frame end detect; cmd/addr/cnt are still then
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			csS1 <= 1'b1;
			csS2 <= 1'b1;
			csS3 <= 1'b1;
		end
		else
		begin
			csS1 <= spi.csN;
			csS2 <= csS1;
			csS3 <= csS2;
		end

	assign frameEnd = csS2 && !csS3 && state != FS_RECOVER;
	assign addrOk = addr[23:16] == 8'h0 && addr[15:13] == 3'h0
		&& addr[11:10] == 2'h0;
	assign locked = |lockBits;
	assign dataEnd = cnt >= `FSH_BITS_DUMMY && cnt[2:0] == 3'h0;
	assign write_in_progress = state == FS_BUSY || state == FS_HALTING;

	always_comb
	begin
		startOp = 1'b0;
		newOp = FO_PROG;
		newTime = 12'(`FSH_PROG_CYC);
		case (cmd)
			`FSH_CMD_SR_ERASE:
			begin
				startOp = cnt == `FSH_BITS_ADDR && addrOk && !locked;
				newOp = FO_SR_ERASE;
				newTime = 12'(`FSH_ERASE_CYC);
			end
			`FSH_CMD_SR_PROG:
			begin
				startOp = dataEnd && addrOk && !locked;
				newOp = FO_SR_PROG;
			end
			`FSH_CMD_PP, `FSH_CMD_QPP:
				startOp = dataEnd;
			`FSH_CMD_SE, `FSH_CMD_BE32, `FSH_CMD_BE64:
			begin
				startOp = cnt == `FSH_BITS_ADDR;
				newOp = FO_ERASE;
				newTime = 12'(`FSH_ERASE_CYC);
			end
			`FSH_CMD_CE1, `FSH_CMD_CE2:
			begin
				startOp = cnt == `FSH_BITS_CMD;
				newOp = FO_ERASE;
				newTime = 12'(`FSH_ERASE_CYC);
			end
			default:
				startOp = 1'b0;
		endcase
		startOp = startOp && frameEnd && write_enable_latch && !write_in_progress
			&& !refused(cmd, paused_state_flag, savedOp);
	end

	// only running array program or erase
	assign takeSuspend = frameEnd && cmd == `FSH_CMD_SUSPEND
		&& cnt == `FSH_BITS_CMD && state == FS_BUSY && !paused_state_flag
		&& (op == FO_PROG || op == FO_ERASE);
	assign takeResume = frameEnd && cmd == `FSH_CMD_RESUME
		&& cnt == `FSH_BITS_CMD && paused_state_flag && !write_in_progress;
	// reset frame right after enable frame
	assign takeReset = frameEnd && cmd == `FSH_CMD_RST
		&& cnt == `FSH_BITS_CMD && rstArm;

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			state <= FS_IDLE;
			op <= FO_PROG;
			savedOp <= FO_PROG;
			timer <= 12'h0;
			savedTimer <= 12'h0;
			haltWait <= 12'h0;
			write_enable_latch <= 1'b0;
			paused_state_flag <= 1'b0;
			rstArm <= 1'b0;
		end
		else
		begin
			case (state)
				FS_BUSY, FS_RECOVER:
					if (timer <= 12'h1)
						state <= (paused_state_flag && state == FS_BUSY) ? FS_HALTED : FS_IDLE;
					else
						timer <= timer - 12'h1;
				FS_HALTING:
					if (haltWait <= 12'h1)
					begin
						state <= FS_HALTED;
						savedOp <= op;
						savedTimer <= timer;
					end
					else
						haltWait <= haltWait - 12'h1;
				default:
					state <= state;
			endcase
			if (frameEnd)
				rstArm <= cmd == `FSH_CMD_RST_EN && cnt == `FSH_BITS_CMD;
			if (frameEnd && cnt == `FSH_BITS_CMD && !write_in_progress)
			begin
				if (cmd == `FSH_CMD_WR_ENABLE)
					write_enable_latch <= 1'b1;
				if (cmd == `FSH_CMD_WR_DISABLE)
					write_enable_latch <= 1'b0;
			end
			if (startOp)
			begin
				state <= FS_BUSY;
				op <= newOp;
				timer <= newTime;
				write_enable_latch <= 1'b0;
			end
			if (takeSuspend)
			begin
				state <= FS_HALTING;
				haltWait <= 12'(`FSH_SUS_CYC);
				paused_state_flag <= 1'b1;
			end
			if (takeResume)
			begin
				state <= FS_BUSY;
				op <= savedOp;
				timer <= savedTimer;
				paused_state_flag <= 1'b0;
			end
			if (takeReset)
			begin
				state <= FS_RECOVER;
				timer <= 12'(`FSH_RST_CYC);
				write_enable_latch <= 1'b0;
				paused_state_flag <= 1'b0;
				rstArm <= 1'b0;
			end
		end

	// array written when the operation starts
	always_ff @(posedge ref_clk)
		if (startOp && newOp == FO_SR_ERASE)
		begin
			for (int i = 0; i < 1024; i++)
				mem[{addr[12], 10'(i)}] <= 8'hff;
		end
		else if (startOp && newOp == FO_SR_PROG)
		begin
			for (int j = 0; j < 256; j++)
				mem[{addr[12], addr[9:8], 8'(j)}]
					<= mem[{addr[12], addr[9:8], 8'(j)}] & pageBuf[j];
		end
endmodule

//--- verilog/fsh_flash_host.sv
// Purpose: host end, runs one flash frame per request
// Assumes: device samples on rising sclk, drives on falling
// Notes: sclk is ref_clk divided by twice the half count
`timescale 1ns/1ps
`include "fsh_map.svh"
module fsh_flash_host
	(
		// Link
		fsh_spi_if.host spi,
		// System
		input wire logic ref_clk,
		input wire logic rst_n,
		// Request
		input wire logic reqValid,
		output logic reqReady,
		input wire logic [7:0] reqCmd,
		input wire logic [23:0] reqAddr,
		input wire logic reqAddrEn,
		input wire logic reqDummyEn,
		input wire logic [10:0] reqLen,
		input wire logic reqWrite,
		// Data
		input wire logic [7:0] wrData,
		output logic wrTake,
		output logic [7:0] rdData,
		output logic rdValid
	);
	import fsh_pkg::*;

	fsh_host_state_e state;
	logic [7:0] cmd;
	logic [23:0] addr;
	logic addrEn;
	logic dummyEn;
	logic write;
	logic [11:0] byteIdx;
	logic [11:0] lastIdx;
	logic [11:0] dataStart;
	logic [2:0] bitIdx;
	logic [2:0] half;
	logic [3:0] gap;
	logic [7:0] txByte;
	logic [7:0] rxByte;
	logic [7:0] nextByte;
	logic nextIsData;
	logic soS1;
	logic soS2;

	assign reqReady = state == HS_IDLE;
	assign dataStart = 12'h1 + (addrEn ? 12'h3 : 12'h0)
		+ (dummyEn ? 12'h1 : 12'h0);
	assign nextIsData = byteIdx + 12'h1 >= dataStart;
	assign wrTake = state == HS_XFER && half == `FSH_HALF_CYC - 3'h1
		&& spi.sclk && bitIdx == 3'h7 && byteIdx != lastIdx
		&& nextIsData && write;

	always_comb
		case (byteIdx + 12'h1 - (addrEn ? 12'h0 : 12'h3))
			12'h1: nextByte = addr[23:16];
			12'h2: nextByte = addr[15:8];
			12'h3: nextByte = addr[7:0];
			default: nextByte = (nextIsData && write) ? wrData : 8'h0;
		endcase

	// Device data line is asynchronous here
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			soS1 <= 1'b1;
			soS2 <= 1'b1;
		end
		else
		begin
			soS1 <= spi.soPin;
			soS2 <= soS1;
		end

	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			state <= HS_IDLE;
			spi.csN <= 1'b1;
			spi.sclk <= 1'b0;
			spi.si <= 1'b0;
			{cmd, addr, addrEn, dummyEn, write} <= 35'h0;
			byteIdx <= 12'h0;
			lastIdx <= 12'h0;
			bitIdx <= 3'h0;
			half <= 3'h0;
			gap <= 4'h0;
			txByte <= 8'h0;
			rxByte <= 8'h0;
			rdData <= 8'h0;
			rdValid <= 1'b0;
		end
		else
		begin
			rdValid <= 1'b0;
			case (state)
				HS_IDLE:
					if (reqValid)
					begin
						state <= HS_XFER;
						spi.csN <= 1'b0;
						{cmd, addr, addrEn, dummyEn, write} <= {reqCmd, reqAddr,
							reqAddrEn, reqDummyEn, reqWrite};
						lastIdx <= 12'(reqLen) + (reqAddrEn ? 12'h3 : 12'h0)
							+ (reqDummyEn ? 12'h1 : 12'h0);
						byteIdx <= 12'h0;
						bitIdx <= 3'h0;
						half <= 3'h0;
						txByte <= reqCmd;
						spi.si <= reqCmd[7];
					end
				HS_XFER:
					if (half != `FSH_HALF_CYC - 3'h1)
						half <= half + 3'h1;
					else if (!spi.sclk)
					begin
						half <= 3'h0;
						spi.sclk <= 1'b1;
						rxByte <= {rxByte[6:0], soS2};
					end
					else
					begin
						half <= 3'h0;
						spi.sclk <= 1'b0;
						bitIdx <= bitIdx + 3'h1;
						if (bitIdx != 3'h7)
						begin
							txByte <= {txByte[6:0], 1'b0};
							spi.si <= txByte[6];
						end
						else
						begin
							if (byteIdx >= dataStart && !write)
							begin
								rdData <= rxByte;
								rdValid <= 1'b1;
							end
							// deselect right after the last byte
							if (byteIdx == lastIdx)
								state <= HS_DESEL;
							byteIdx <= byteIdx + 12'h1;
							txByte <= nextByte;
							spi.si <= nextByte[7];
						end
					end
				HS_DESEL:
					if (half != `FSH_HALF_CYC - 3'h1)
						half <= half + 3'h1;
					else
					begin
						// each command is its own frame
						spi.csN <= 1'b1;
						gap <= 4'h0;
						state <= HS_GAP;
					end
				HS_GAP:
					if (gap == `FSH_GAP_CYC - 4'h1)
						state <= HS_IDLE;
					else
						gap <= gap + 4'h1;
				default:
					state <= HS_IDLE;
			endcase
		end
endmodule

//--- verilog/fsh_map.svh
// Purpose: constants shared by both flash link ends
// Assumes: reference clock of 40 MHz
// Notes: times in ns, cycle counts derived from them
`ifndef FSH_MAP_SVH
`define FSH_MAP_SVH

`define FSH_CLK_NS 25
`define FSH_CMD_WR_ENABLE 8'h06
`define FSH_CMD_WR_DISABLE 8'h04
`define FSH_CMD_RD_STATUS 8'h05
`define FSH_CMD_WR_STATUS 8'h01
`define FSH_CMD_UID 8'h4b
`define FSH_CMD_SR_ERASE 8'h44
`define FSH_CMD_SR_PROG 8'h42
`define FSH_CMD_SR_READ 8'h48
`define FSH_CMD_RST_EN 8'h66
`define FSH_CMD_RST 8'h99
`define FSH_CMD_SUSPEND 8'h75
`define FSH_CMD_RESUME 8'h7a
`define FSH_CMD_PP 8'h02
`define FSH_CMD_QPP 8'h32
`define FSH_CMD_SE 8'h20
`define FSH_CMD_BE32 8'h52
`define FSH_CMD_BE64 8'hd8
`define FSH_CMD_CE1 8'hc7
`define FSH_CMD_CE2 8'h60

// Bits received at the end of each frame part
`define FSH_BITS_CMD 20'h8
`define FSH_BITS_ADDR 20'h20
`define FSH_BITS_DUMMY 20'h28

// Status byte positions
`define FSH_ST_WIP 0
`define FSH_ST_WEL 1
`define FSH_ST_SUS 7

`define FSH_ERASE_NS 90000
`define FSH_PROG_NS 20000
`define FSH_RST_NS 30000
`define FSH_SUS_NS 2000
`define FSH_ERASE_CYC ((`FSH_ERASE_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_PROG_CYC ((`FSH_PROG_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_RST_CYC ((`FSH_RST_NS + `FSH_CLK_NS - 1) / `FSH_CLK_NS)
`define FSH_SUS_CYC (`FSH_SUS_NS / `FSH_CLK_NS)

// Host link clock: half period and deselect gap in ref cycles
`define FSH_HALF_CYC 3'h4
`define FSH_GAP_CYC 4'h8

`endif

//--- verilog/fsh_pkg.sv
// Purpose: types shared by both flash link ends
// Assumes: nothing
// Notes: encodings left to the tools
package fsh_pkg;
	typedef enum logic [2:0] {FS_IDLE, FS_BUSY, FS_HALTING, FS_HALTED,
		FS_RECOVER} fsh_dev_state_e;
	typedef enum logic [1:0] {FO_SR_ERASE, FO_SR_PROG, FO_PROG,
		FO_ERASE} fsh_op_e;
	typedef enum logic [1:0] {HS_IDLE, HS_XFER, HS_DESEL,
		HS_GAP} fsh_host_state_e;
endpackage

//--- verilog/fsh_spi_if.sv
// Purpose: serial flash link between host and device
// Assumes: data out line pulled high when undriven
// Notes: soPin is the resolved wire level
`timescale 1ns/1ps
interface fsh_spi_if;
	logic csN;
	logic sclk;
	logic si;
	logic so;
	logic soOe;
	logic soPin;

	assign soPin = soOe ? so : 1'b1;

	modport dev
	(
		input csN, sclk, si,
		output so, soOe
	);
	modport host
	(
		output csN, sclk, si,
		input soPin
	);
endinterface
